// ===== src/fcsi_map.svh
// register map, field positions, reset values and codes of the flash timing/security bank
`ifndef FCSI_MAP_SVH
`define FCSI_MAP_SVH

// ********************************
// register indices (byte address = 4 * index)
// ********************************
`define FCSI_IDX_DIVIDER        4'h0
`define FCSI_IDX_SECURITY       4'h1
`define FCSI_IDX_CMD_INDEX      4'h2
`define FCSI_IDX_ECC_INDEX      4'h3
`define FCSI_IDX_STATUS         4'h4
`define FCSI_IDX_W              4

// ********************************
// field positions
// ********************************
`define FCSI_DIV_LOADED_BIT     7
`define FCSI_DIV_VALUE_HI       6
`define FCSI_KEYEN_HI           7
`define FCSI_KEYEN_LO           6
`define FCSI_SEC_HI             1
`define FCSI_SEC_LO             0
`define FCSI_INDEX_HI           2
`define FCSI_STAT_CMD_DONE_BIT  0
`define FCSI_STAT_RST_SEQ_BIT   1
`define FCSI_STAT_KEY_EN_BIT    2
`define FCSI_STAT_UNSEC_BIT     3
`define FCSI_STAT_LOADED_BIT    4

// ********************************
// codes and reset values
// ********************************
`define FCSI_KEYEN_ENABLED      2'h2
`define FCSI_SEC_UNSECURED      2'h2
`define FCSI_SECURITY_RST       8'hff
`define FCSI_DIV_RST            7'h00
`define FCSI_INDEX_RST          3'h0
`define FCSI_RESP_OKAY          2'h0
`define FCSI_RESP_SLVERR        2'h2

`endif

// ===== src/fcsi_pkg.sv
// types shared by the flash timing/security register bank
package fcsi_pkg;

   // security byte delivered by the reset-sequence read of the configuration field
   typedef struct packed {
      logic       valid;
      logic       doubleFault;
      logic [7:0] data;
   } fcsi_sec_load_t;

   // state of the register bank, apart from the decoded security flags, the registered timing tick and the divider counter
   typedef struct packed {
      logic       awHeld;
      logic       wHeld;
      logic [3:0] awIndex;
      logic [7:0] wByte;
      logic       wLane0;
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rByte;
      logic       dividerLoaded;
      logic [6:0] dividerValue;
      logic [7:0] security;
      logic [2:0] commandIndex;
      logic [2:0] eccIndex;
      logic       stepGo;
   } fcsi_state_t;

   // divider counter state
   typedef struct packed {
      logic [6:0] count;
      logic       tick;
   } fcsi_div_state_t;

endpackage

// ===== src/fcsi_clk_div.sv
// divides the oscillator clock into a one-cycle timing enable pulse
`timescale 1ns/1ps
`include "fcsi_map.svh"

module fcsi_clk_div
   import fcsi_pkg::*;
#(
   parameter int DIV_W = 7
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic             enable,
   input  wire logic [DIV_W-1:0] divisor,
   // timing enable
   output logic                  tick
);

   fcsi_div_state_t s;
   fcsi_div_state_t next_s;

   // ********************************
   // counter
   // ********************************
   // a divisor of zero means no usable clock, so no tick is produced
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!enable || divisor == '0) begin
         next_s.count = '0;
      end else if (s.count >= divisor - 7'h01) begin
         next_s.count = '0;
         next_s.tick  = 1'b1;
      end else begin
         next_s.count = s.count + 7'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule

// ===== src/fcsi_regs.sv
// flash timing divider, security and index register bank behind an AXI4-Lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fcsi_map.svh"

module fcsi_regs
   import fcsi_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 7
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // axi4-lite write address channel
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // axi4-lite write data channel
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // axi4-lite write response channel
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read address channel
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // axi4-lite read data channel
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // flash controller status
   input  wire logic                commandCompleteFlag,
   input  wire logic                resetSequenceActive,
   // security byte load and backdoor unlock
   input  wire fcsi_sec_load_t      securityLoad,
   input  wire logic                backdoorUnsecure,
   // timed step handshake with the algorithm sequencer
   input  wire logic                stepRequest,
   output logic                     stepGo,
   // timing and security outputs
   output logic                     flashTimingTick,
   output logic                     dividerLoadedFlag,
   output logic                     backdoorKeyEnabled,
   output logic                     deviceUnsecured,
   // array word selects
   output logic [2:0]               commandWordIndex,
   output logic [2:0]               eccResultIndex
);

   // ********************************
   // state
   // ********************************
   fcsi_state_t s;
   fcsi_state_t next_s;
   logic        tick;
   logic [3:0]  arIndex;
   logic [7:0]  readByte;
   logic        readHit;
   logic        writeHit;
   logic [7:0]  statusByte;

   // prot is accepted but does not restrict access in this bank
   logic        protUnused;
   assign protUnused = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

   assign arIndex = s_axi_araddr[`FCSI_IDX_W+1:2];

   // ********************************
   // timing clock divider
   // ********************************
   // the divider only runs once a value has been written, so a
   // half-configured clock never reaches the algorithms
   fcsi_clk_div #(
      .DIV_W   (DIV_W)
   ) u_div (
      .clk     (clk),
      .rst     (rst),
      .enable  (s.dividerLoaded),
      .divisor (s.dividerValue),
      .tick    (tick)
   );

   // ********************************
   // read decode
   // ********************************
   always_comb begin
      statusByte = 8'h00;
      statusByte[`FCSI_STAT_CMD_DONE_BIT] = commandCompleteFlag;
      statusByte[`FCSI_STAT_RST_SEQ_BIT]  = resetSequenceActive;
      statusByte[`FCSI_STAT_KEY_EN_BIT]   = backdoorKeyEnabled;
      statusByte[`FCSI_STAT_UNSEC_BIT]    = deviceUnsecured;
      statusByte[`FCSI_STAT_LOADED_BIT]   = s.dividerLoaded;
   end

   always_comb begin
      readByte = 8'h00;
      readHit  = 1'b1;
      if (s_axi_araddr[1:0] != 2'h0) begin
         readHit = 1'b0;
      end else if (arIndex == `FCSI_IDX_DIVIDER) begin
         readByte = {s.dividerLoaded, s.dividerValue};
      end else if (arIndex == `FCSI_IDX_SECURITY) begin
         readByte = s.security;
      end else if (arIndex == `FCSI_IDX_CMD_INDEX) begin
         readByte = {5'h00, s.commandIndex};
      end else if (arIndex == `FCSI_IDX_ECC_INDEX) begin
         readByte = {5'h00, s.eccIndex};
      end else if (arIndex == `FCSI_IDX_STATUS) begin
         readByte = statusByte;
      end else begin
         readHit = 1'b0;
      end
   end

   // ********************************
   // write address check
   // ********************************
   always_comb begin
      writeHit = 1'b0;
      if (s.awIndex == `FCSI_IDX_DIVIDER || s.awIndex == `FCSI_IDX_SECURITY ||
          s.awIndex == `FCSI_IDX_CMD_INDEX || s.awIndex == `FCSI_IDX_ECC_INDEX ||
          s.awIndex == `FCSI_IDX_STATUS) begin
         writeHit = 1'b1;
      end
   end

   // ********************************
   // next state
   // ********************************
   always_comb begin
      next_s        = s;
      next_s.stepGo = 1'b0;

      // write address and data are taken independently, in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.awHeld = 1'b1;
         if (s_axi_awaddr[1:0] != 2'h0) begin
            next_s.awIndex = 4'hf;
         end else begin
            next_s.awIndex = s_axi_awaddr[`FCSI_IDX_W+1:2];
         end
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wHeld  = 1'b1;
         next_s.wByte  = s_axi_wdata[7:0];
         next_s.wLane0 = s_axi_wstrb[0];
      end

      // response goes out once both halves have been taken
      if (s.awHeld && s.wHeld && !s.bvalid) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = writeHit ? `FCSI_RESP_OKAY : `FCSI_RESP_SLVERR;
         if (s.wLane0) begin
            if (s.awIndex == `FCSI_IDX_DIVIDER) begin
               // accepted even with the command-complete flag low, which
               // covers writes made while the reset sequence runs
               if (!s.dividerLoaded) begin
                  next_s.dividerValue  = s.wByte[`FCSI_DIV_VALUE_HI:0];
                  next_s.dividerLoaded = 1'b1;
               end
            end else if (s.awIndex == `FCSI_IDX_CMD_INDEX) begin
               next_s.commandIndex = s.wByte[`FCSI_INDEX_HI:0];
            end else if (s.awIndex == `FCSI_IDX_ECC_INDEX) begin
               next_s.eccIndex = s.wByte[`FCSI_INDEX_HI:0];
            end
            // security and status take no write: the response is still OKAY
         end
      end else if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // read: one outstanding, answered the cycle after the address
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rByte  = readByte;
         next_s.rresp  = readHit ? `FCSI_RESP_OKAY : `FCSI_RESP_SLVERR;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // security byte arrives once from the reset-sequence read
      if (securityLoad.valid) begin
         if (securityLoad.doubleFault) begin
            next_s.security = `FCSI_SECURITY_RST;
         end else begin
            next_s.security = securityLoad.data;
         end
      end else if (backdoorUnsecure && backdoorKeyEnabled) begin
         next_s.security[`FCSI_SEC_HI:`FCSI_SEC_LO] = `FCSI_SEC_UNSECURED;
      end

      // a timed step only starts on a tick of a loaded divider
      if (stepRequest && s.dividerLoaded && tick) begin
         next_s.stepGo = 1'b1;
      end

      next_s.awready = !next_s.awHeld && !next_s.bvalid;
      next_s.wready  = !next_s.wHeld && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge clk) begin
      if (rst) begin
         s              <= '0;
         s.security     <= `FCSI_SECURITY_RST;
         s.dividerValue <= `FCSI_DIV_RST;
         s.commandIndex <= `FCSI_INDEX_RST;
         s.eccIndex     <= `FCSI_INDEX_RST;
      end else begin
         s <= next_s;
      end
   end

   // ********************************
   // decoded security flags and registered timing tick
   // ********************************
   // registered so every output comes from a flip-flop; they lag the
   // security byte by one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         backdoorKeyEnabled <= 1'b0;
         deviceUnsecured    <= 1'b0;
         flashTimingTick    <= 1'b0;
      end else begin
         backdoorKeyEnabled <= (s.security[`FCSI_KEYEN_HI:`FCSI_KEYEN_LO]
                                == `FCSI_KEYEN_ENABLED);
         deviceUnsecured    <= (s.security[`FCSI_SEC_HI:`FCSI_SEC_LO]
                                == `FCSI_SEC_UNSECURED);
         flashTimingTick    <= tick;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign s_axi_awready     = s.awready;
   assign s_axi_wready      = s.wready;
   assign s_axi_bvalid      = s.bvalid;
   assign s_axi_bresp       = s.bresp;
   assign s_axi_arready     = s.arready;
   assign s_axi_rvalid      = s.rvalid;
   assign s_axi_rresp       = s.rresp;
   assign s_axi_rdata       = {24'h000000, s.rByte};
   assign stepGo            = s.stepGo;
   assign dividerLoadedFlag = s.dividerLoaded;
   assign commandWordIndex  = s.commandIndex;
   assign eccResultIndex    = s.eccIndex;

endmodule

// ===== verif/fcsi_regs_monitor.sv
// concurrent checks on the ports of the flash timing/security register bank
`timescale 1ns/1ps

module fcsi_regs_monitor
   import fcsi_pkg::*;
(
   // clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // read data channel
   input  wire logic [31:0]    s_axi_rdata,
   input  wire logic           s_axi_rvalid,
   // control inputs
   input  wire fcsi_sec_load_t securityLoad,
   input  wire logic           backdoorUnsecure,
   input  wire logic           stepRequest,
   // observed outputs
   input  wire logic           stepGo,
   input  wire logic           flashTimingTick,
   input  wire logic           dividerLoadedFlag,
   input  wire logic           backdoorKeyEnabled,
   input  wire logic           deviceUnsecured
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ********************************
   // divider and timed steps
   // ********************************
   AST_LOADED_STICKY: assert property (dividerLoadedFlag |=> dividerLoadedFlag)
      else $error("divider loaded flag dropped");
   AST_TICK_LOADED: assert property (flashTimingTick |-> dividerLoadedFlag)
      else $error("timing tick before divider loaded");
   AST_STEP_GATED: assert property (
      stepGo |-> dividerLoadedFlag && flashTimingTick && $past(stepRequest))
      else $error("step started without request, tick or load");

   // ********************************
   // security decode
   // ********************************
   // a second load or unlock right behind the first would change the figure, so it is excluded
   AST_KEY_DECODE: assert property (
      (securityLoad.valid && !securityLoad.doubleFault ##1 !securityLoad.valid) |->
      ##1 (backdoorKeyEnabled == ($past(securityLoad.data[7:6], 2) == 2'h2)))
      else $error("key enable decode wrong");
   AST_UNSEC_DECODE: assert property (
      (securityLoad.valid && !securityLoad.doubleFault ##1
       !securityLoad.valid && !backdoorUnsecure) |->
      ##1 (deviceUnsecured == ($past(securityLoad.data[1:0], 2) == 2'h2)))
      else $error("security state decode wrong");
   AST_DOUBLE_FAULT: assert property (
      (securityLoad.valid && securityLoad.doubleFault ##1 !securityLoad.valid) |->
      ##1 (!backdoorKeyEnabled && !deviceUnsecured))
      else $error("double fault did not secure the part");
   AST_BACKDOOR: assert property (
      (backdoorUnsecure && backdoorKeyEnabled && !securityLoad.valid &&
       !$past(securityLoad.valid) ##1 !securityLoad.valid) |-> ##1 deviceUnsecured)
      else $error("backdoor unlock did not unsecure");
   AST_RESET_SECURED: assert property ($fell(rst) |-> !backdoorKeyEnabled && !deviceUnsecured)
      else $error("part not secured after reset");
   AST_RDATA_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("unused read bits not zero");

   cover property (stepGo);
   cover property ($rose(deviceUnsecured));
   cover property (flashTimingTick ##3 flashTimingTick);
endmodule

bind fcsi_regs fcsi_regs_monitor u_monitor (.clk, .rst, .s_axi_rdata, .s_axi_rvalid,
   .securityLoad, .backdoorUnsecure, .stepRequest, .stepGo, .flashTimingTick,
   .dividerLoadedFlag, .backdoorKeyEnabled, .deviceUnsecured);

// ===== verif/fcsi_regs_bench.sv
// self-checking bench of the flash timing/security register bank
`timescale 1ns/1ps

module fcsi_regs_bench
   import fcsi_pkg::*;
;
   logic           clk, rst;
   logic [7:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]    s_axi_wdata, s_axi_rdata;
   logic [1:0]     s_axi_bresp, s_axi_rresp;
   logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic           s_axi_rvalid, s_axi_rready, commandCompleteFlag, resetSequenceActive;
   logic           backdoorUnsecure, stepRequest, stepGo, flashTimingTick;
   logic           dividerLoadedFlag, backdoorKeyEnabled, deviceUnsecured;
   logic [2:0]     commandWordIndex, eccResultIndex;
   fcsi_sec_load_t securityLoad;
   int             n_fail, compares;

   fcsi_regs DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .commandCompleteFlag, .resetSequenceActive, .securityLoad,
      .backdoorUnsecure, .stepRequest, .stepGo, .flashTimingTick, .dividerLoadedFlag,
      .backdoorKeyEnabled, .deviceUnsecured, .commandWordIndex, .eccResultIndex);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ********************************
   // compare and bus tasks
   // ********************************
   task chkD(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task chkF(input logic got, input logic exp);
      chkD({31'h0, got}, {31'h0, exp});
   endtask

   // address and data released each at its own handshake; only the watchdog ends a wait
   task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chkD({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
   endtask

   task axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chkD({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
      chkD(s_axi_rdata, ed);
   endtask

   // flags are read three edges after the pulse is raised
   task secLoad(input logic df, input logic [7:0] d);
      @(posedge clk);
      securityLoad <= '{1'b1, df, d};
      @(posedge clk);
      securityLoad.valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ********************************
   // scenarios
   // ********************************
   task tReset;
      logic seen;
      seen = 1'b0;
      axiRd(8'h00, 32'h0, 2'h0);
      chkF(dividerLoadedFlag, 1'b0);
      axiRd(8'h04, 32'hff, 2'h0);
      axiRd(8'h08, 32'h0, 2'h0);
      axiRd(8'h0c, 32'h0, 2'h0);
      stepRequest <= 1'b1;
      repeat (20) begin
         @(posedge clk);
         seen = seen | stepGo | flashTimingTick;
      end
      stepRequest <= 1'b0;
      chkF(seen, 1'b0);
      $display("reset test done");
   endtask

   task tDivider;
      int c;
      // divider is only written while the reset sequence runs
      resetSequenceActive <= 1'b1;
      commandCompleteFlag <= 1'b0;
      axiWr(8'h00, 32'h03, 2'h0);
      axiRd(8'h00, 32'h83, 2'h0);
      chkF(dividerLoadedFlag, 1'b1);
      axiWr(8'h00, 32'h05, 2'h0);
      axiRd(8'h00, 32'h83, 2'h0);
      axiRd(8'h10, 32'h12, 2'h0);
      for (int i = 0; i < 2; i++) begin
         c = 0;
         do begin
            @(posedge clk);
            c++;
         end while (!flashTimingTick && c < 50);
      end
      chkD(c, 32'h3);
      stepRequest <= 1'b1;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (!stepGo && c < 20);
      chkF(stepGo & flashTimingTick, 1'b1);
      stepRequest <= 1'b0;
      resetSequenceActive <= 1'b0;
      commandCompleteFlag <= 1'b1;
      $display("divider test done");
   endtask

   task tIndex;
      axiWr(8'h08, 32'hff, 2'h0);
      axiRd(8'h08, 32'h07, 2'h0);
      chkD({29'h0, commandWordIndex}, 32'h7);
      axiWr(8'h0c, 32'hfa, 2'h0);
      axiRd(8'h0c, 32'h02, 2'h0);
      chkD({29'h0, eccResultIndex}, 32'h2);
      axiWr(8'h09, 32'h0, 2'h2);
      axiRd(8'h08, 32'h07, 2'h0);
      axiRd(8'h14, 32'h0, 2'h2);
      $display("index test done");
   endtask

   task tSecurity;
      for (int i = 0; i < 4; i++) begin
         secLoad(1'b0, {i[1:0], 4'hf, ~i[1:0]});
         chkF(backdoorKeyEnabled, i == 2);
         chkF(deviceUnsecured, i == 1);
         axiRd(8'h04, {24'h0, i[1:0], 4'hf, ~i[1:0]}, 2'h0);
      end
      secLoad(1'b0, 8'hbd);
      axiWr(8'h04, 32'h0, 2'h0);
      axiRd(8'h04, 32'hbd, 2'h0);
      @(posedge clk);
      backdoorUnsecure <= 1'b1;
      @(posedge clk);
      backdoorUnsecure <= 1'b0;
      repeat (2) @(posedge clk);
      chkF(deviceUnsecured, 1'b1);
      axiRd(8'h04, 32'hbe, 2'h0);
      secLoad(1'b1, 8'h82);
      chkF(backdoorKeyEnabled | deviceUnsecured, 1'b0);
      axiRd(8'h04, 32'hff, 2'h0);
      $display("security test done");
   endtask

   task finish_test;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      finish_test;
   end

   initial begin
      n_fail = 0;
      compares = 0;
      rst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {resetSequenceActive, backdoorUnsecure, stepRequest} = '0;
      commandCompleteFlag = 1'b1;
      securityLoad = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tReset;
      tDivider;
      tIndex;
      tSecurity;
      finish_test;
   end
endmodule
